// [src/core_control_pins_pkg.sv]
// Overview of operation
// - Reset pin low halts execution and holds the program counter at the reset vector.
// - Reset pin release starts fetching from the reset vector in program space.
// - Map select low at reset maps internal ROM into the top 16K words.
// - Map select high at reset keeps internal ROM out of program space.
// - Map select pin sampled only at reset; a mode register write overrides it.
// - Branch condition low lets the testing instruction execute; high suppresses it.
// - Conditional execute samples at decode phase; other instructions sample at read phase.
// - Flag is latched: set instruction raises it; clear or status load drops it.
// - Reset drives the external flag high.
// - Output float low puts flag, space selects and memory strobe in high impedance.
// - Space selects stay high; only the accessed space goes low while address valid.
// - Bus hold puts all three space selects in high impedance.
// - Memory strobe goes low only for external data or program accesses.
// - Bus hold puts the memory strobe in high impedance.
package core_control_pins_pkg;
  // ==========================================================
  // Fetch addresses
  localparam logic [15:0] RESET_VECTOR = 16'hff80;
  // Start of the top 16K words of program space.
  localparam logic [15:0] ROM_BASE = 16'hc000;
  // ==========================================================
  // Register map
  localparam logic [3:0] MODE_STATUS_OFS = 4'h0;
  localparam logic [3:0] STATUS1_OFS = 4'h4;
  localparam logic [3:0] STATE_OFS = 4'h8;
  localparam int MAP_BIT = 0;
  localparam int ST_FLAG_BIT = 0;
  localparam int ST_MAP_BIT = 1;
  localparam int ST_RUN_BIT = 2;
  localparam int ST_COND_BIT = 3;
  localparam logic [15:0] READ_ZERO = 16'h0000;
  // ==========================================================
  // External space codes
  localparam logic [1:0] SPACE_DATA = 2'h0;
  localparam logic [1:0] SPACE_PROGRAM = 2'h1;
  localparam logic [1:0] SPACE_IO = 2'h2;
  typedef enum logic {RUN_HALTED, RUN_FETCHING} run_state_t;
endpackage : core_control_pins_pkg

// [src/core_control_pins.sv]
`timescale 1ns/100ps
module core_control_pins #(
  parameter int PC_W = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  // Reset and mapping pins
  input wire logic reset_in_n,
  input wire logic rom_map_select,
  // Fetch side
  output logic [PC_W-1:0] program_counter,
  output logic core_running,
  output logic rom_mapped,
  output logic rom_select,
  // Branch condition
  input wire logic branch_condition_in_n,
  input wire logic decode_phase,
  input wire logic read_phase,
  input wire logic cond_test,
  input wire logic cond_is_exec,
  output logic cond_valid,
  output logic cond_execute,
  // External flag
  input wire logic set_status_bit_instr,
  input wire logic clear_status_bit_instr,
  output logic external_flag_out,
  output logic external_flag_oe,
  // External bus control
  input wire logic output_float_n,
  input wire logic bus_hold,
  input wire logic access_valid,
  input wire logic [1:0] access_space,
  output logic data_space_sel_n,
  output logic program_space_sel_n,
  output logic io_space_sel_n,
  output logic space_sel_oe,
  output logic memory_strobe_n,
  output logic memory_strobe_oe
);

  // ==========================================================
  // Elaboration check
  if (PC_W != 16) begin : g_bad_width
    $error("PC_W must be 16 to hold the reset vector");
  end

  // ==========================================================
  // State
  typedef struct packed {
    core_control_pins_pkg::run_state_t run;
    logic [15:0] pc;
    logic map_mp;
    logic flag;
    logic cond_dec;
    logic cond_rd;
    logic rom_on;
    logic running;
    logic cond_valid;
    logic cond_exec;
    logic [15:0] rdata;
    logic rom_sel;
    logic flag_oe;
    logic [2:0] sel_n;
    logic sel_oe;
    logic strobe_n;
    logic strobe_oe;
  } state_t;

  state_t st;
  state_t next_st;
  logic [15:0] state_word;

  // Status word that software reads back.
  always_comb begin
    state_word = core_control_pins_pkg::READ_ZERO;
    state_word[core_control_pins_pkg::ST_FLAG_BIT] = st.flag;
    state_word[core_control_pins_pkg::ST_MAP_BIT] = st.map_mp;
    state_word[core_control_pins_pkg::ST_RUN_BIT] =
      (st.run == core_control_pins_pkg::RUN_FETCHING);
    state_word[core_control_pins_pkg::ST_COND_BIT] = st.cond_exec;
  end

  // ==========================================================
  // Next state
  always_comb begin
    next_st = st;
    next_st.cond_valid = 1'b0;
    // Reset pin and fetch sequencing.
    if (!reset_in_n) begin
      next_st.run = core_control_pins_pkg::RUN_HALTED;
      next_st.pc = core_control_pins_pkg::RESET_VECTOR;
      // The map mode only follows the pin while reset is held.
      next_st.map_mp = rom_map_select;
    end else begin
      unique case (st.run)
        core_control_pins_pkg::RUN_HALTED: begin
          next_st.run = core_control_pins_pkg::RUN_FETCHING;
          next_st.pc = core_control_pins_pkg::RESET_VECTOR;
        end
        core_control_pins_pkg::RUN_FETCHING: begin
          next_st.pc = st.pc + 16'h0001;
        end
      endcase
      if (reg_write && reg_addr == core_control_pins_pkg::MODE_STATUS_OFS) begin
        next_st.map_mp = reg_wdata[core_control_pins_pkg::MAP_BIT];
      end
    end
    // Mode and run flags get flops of their own so the pins carry no gate.
    next_st.rom_on = !next_st.map_mp;
    next_st.running = (next_st.run == core_control_pins_pkg::RUN_FETCHING);
    // Internal ROM decode of the address that is being fetched.
    next_st.rom_sel = !next_st.map_mp && (next_st.pc >= core_control_pins_pkg::ROM_BASE);
    // Branch condition sampling per pipeline phase.
    if (decode_phase) begin
      next_st.cond_dec = branch_condition_in_n;
    end
    if (read_phase) begin
      next_st.cond_rd = branch_condition_in_n;
    end
    if (cond_test) begin
      next_st.cond_valid = 1'b1;
      next_st.cond_exec = cond_is_exec ? !st.cond_dec : !st.cond_rd;
    end
    // External flag. A set in the same cycle as a clear wins, as the later-written
    // value would in software order matters less than never losing a raise.
    if (!reset_in_n) begin
      next_st.flag = 1'b1;
    end else if (set_status_bit_instr) begin
      next_st.flag = 1'b1;
    end else if (clear_status_bit_instr ||
                 (reg_write && reg_addr == core_control_pins_pkg::STATUS1_OFS)) begin
      next_st.flag = 1'b0;
    end
    // Register reads answer in the following cycle only.
    next_st.rdata = core_control_pins_pkg::READ_ZERO;
    if (reg_read) begin
      unique case (reg_addr)
        core_control_pins_pkg::MODE_STATUS_OFS: begin
          next_st.rdata = {15'h0000, st.map_mp};
        end
        core_control_pins_pkg::STATUS1_OFS: begin
          next_st.rdata = {15'h0000, st.flag};
        end
        core_control_pins_pkg::STATE_OFS: begin
          next_st.rdata = state_word;
        end
        default: begin
          next_st.rdata = core_control_pins_pkg::READ_ZERO;
        end
      endcase
    end
    // Bus control pins. Every pin is registered, so enables lag their cause by
    // one cycle; this keeps glitches off the board at the cost of latency.
    next_st.flag_oe = output_float_n;
    next_st.sel_oe = output_float_n && !bus_hold;
    next_st.strobe_oe = output_float_n && !bus_hold;
    next_st.sel_n[0] = !(access_valid && access_space == core_control_pins_pkg::SPACE_DATA);
    next_st.sel_n[1] = !(access_valid && access_space == core_control_pins_pkg::SPACE_PROGRAM);
    next_st.sel_n[2] = !(access_valid && access_space == core_control_pins_pkg::SPACE_IO);
    next_st.strobe_n = !(access_valid && !bus_hold &&
                         (access_space == core_control_pins_pkg::SPACE_DATA ||
                          access_space == core_control_pins_pkg::SPACE_PROGRAM));
    if (bus_hold) begin
      next_st.sel_n = 3'h7;
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      st.run <= core_control_pins_pkg::RUN_HALTED;
      st.pc <= core_control_pins_pkg::RESET_VECTOR;
      st.map_mp <= 1'b0;
      st.flag <= 1'b1;
      st.cond_dec <= 1'b1;
      st.cond_rd <= 1'b1;
      st.rom_on <= 1'b1;
      st.running <= 1'b0;
      st.cond_valid <= 1'b0;
      st.cond_exec <= 1'b0;
      st.rdata <= core_control_pins_pkg::READ_ZERO;
      st.rom_sel <= 1'b0;
      st.flag_oe <= 1'b0;
      st.sel_n <= 3'h7;
      st.sel_oe <= 1'b0;
      st.strobe_n <= 1'b1;
      st.strobe_oe <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Outputs
  assign reg_rdata = st.rdata;
  assign program_counter = st.pc;
  assign core_running = st.running;
  assign rom_mapped = st.rom_on;
  assign rom_select = st.rom_sel;
  assign cond_valid = st.cond_valid;
  assign cond_execute = st.cond_exec;
  assign external_flag_out = st.flag;
  assign external_flag_oe = st.flag_oe;
  assign data_space_sel_n = st.sel_n[0];
  assign program_space_sel_n = st.sel_n[1];
  assign io_space_sel_n = st.sel_n[2];
  assign space_sel_oe = st.sel_oe;
  assign memory_strobe_n = st.strobe_n;
  assign memory_strobe_oe = st.strobe_oe;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  reset_vector_hold_a: assert property (
    !reset_in_n |=> !core_running && program_counter == core_control_pins_pkg::RESET_VECTOR)
    else $error("program counter not at reset vector during reset");

  release_fetch_a: assert property (
    !reset_in_n ##1 reset_in_n |=> core_running &&
      program_counter == core_control_pins_pkg::RESET_VECTOR)
    else $error("fetch did not start at reset vector");

  pc_step_a: assert property (
    reset_in_n && core_running |=> program_counter == $past(program_counter) + 16'h0001)
    else $error("program counter did not step while fetching");

  map_high_a: assert property (
    !reset_in_n && rom_map_select |=> !rom_mapped)
    else $error("ROM mapped although map pin high at reset");

  map_latch_a: assert property (
    !reset_in_n |=> rom_mapped == !$past(rom_map_select))
    else $error("map mode not latched from pin at reset");

  map_sticky_a: assert property (
    reset_in_n && $past(reset_in_n) &&
      !(reg_write && reg_addr == core_control_pins_pkg::MODE_STATUS_OFS)
      |=> $stable(rom_mapped))
    else $error("map mode changed without reset or register write");

  cond_select_a: assert property (
    decode_phase ##1 !decode_phase ##1 (cond_test && cond_is_exec && !decode_phase) |=>
      cond_valid && cond_execute == !$past(branch_condition_in_n, 3))
    else $error("conditional execute used wrong sample");

  cond_read_a: assert property (
    read_phase ##1 (cond_test && !cond_is_exec && !read_phase) |=>
      cond_valid && cond_execute == !$past(branch_condition_in_n, 2))
    else $error("conditional instruction used wrong read sample");

  flag_latch_a: assert property (
    reset_in_n && set_status_bit_instr |=> external_flag_out)
    else $error("flag not set by set instruction");

  flag_clear_a: assert property (
    reset_in_n && !set_status_bit_instr && clear_status_bit_instr |=> !external_flag_out)
    else $error("flag not cleared by clear instruction");

  flag_reset_a: assert property (
    !reset_in_n |=> external_flag_out)
    else $error("flag not high after reset pin");

  float_off_a: assert property (
    !output_float_n |=> !external_flag_oe && !space_sel_oe && !memory_strobe_oe)
    else $error("outputs driven while float is low");

  hold_float_a: assert property (
    bus_hold |=> !space_sel_oe && !memory_strobe_oe)
    else $error("bus pins driven in hold");

  strobe_hold_a: assert property (
    bus_hold |=> memory_strobe_n && data_space_sel_n && program_space_sel_n)
    else $error("strobe or select active in hold");

  select_data_a: assert property (
    access_valid && access_space == core_control_pins_pkg::SPACE_DATA && !bus_hold
      |=> !data_space_sel_n)
    else $error("data space select not low for data access");

  select_onehot_a: assert property (
    1'b1 |=> $countones({data_space_sel_n, program_space_sel_n, io_space_sel_n}) >= 2)
    else $error("more than one space select low");

  strobe_io_a: assert property (
    access_valid && access_space == core_control_pins_pkg::SPACE_IO |=> memory_strobe_n)
    else $error("memory strobe low for I/O access");

  reset_cycle_c: cover property (!reset_in_n ##1 reset_in_n ##2 core_running);
  exec_taken_c: cover property (cond_valid && cond_execute);
  data_access_c: cover property (!data_space_sel_n && !memory_strobe_n && space_sel_oe);
  flag_toggle_c: cover property (external_flag_out ##1 !external_flag_out);

endmodule : core_control_pins

// [dv/far_side_model.sv]
`timescale 1ns/100ps
// ==========================================================
// Far side: a peer processor driving the branch condition and an outside bus master.
module far_side_model (
  // Commands from the bench
  input wire logic cond_pin_cmd,
  input wire logic hold_cmd,
  input wire logic float_cmd,
  // Pins toward the device
  output logic branch_condition_in_n,
  output logic bus_hold,
  output logic output_float_n
);
  // The outside master never takes the lines unasked; hold only follows its own request.
  assign bus_hold = hold_cmd;
  assign branch_condition_in_n = cond_pin_cmd;
  assign output_float_n = float_cmd;
endmodule : far_side_model

// [dv/test_core_control_pins.sv]
`timescale 1ns/100ps
module test_core_control_pins;
  // ==========================================================
  // Stimulus and observed signals
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_write = 1'b0, reg_read = 1'b0, reset_in_n = 1'b1, rom_map_select = 1'b0;
  logic decode_phase = 1'b0, read_phase = 1'b0, cond_test = 1'b0, cond_is_exec = 1'b0;
  logic set_status_bit_instr = 1'b0, clear_status_bit_instr = 1'b0, access_valid = 1'b0;
  logic cond_pin_cmd = 1'b1, hold_cmd = 1'b0, float_cmd = 1'b1;
  logic [1:0] access_space = 2'h0;
  logic [15:0] reg_rdata, program_counter;
  logic core_running, rom_mapped, rom_select, cond_valid, cond_execute, external_flag_out;
  logic external_flag_oe, data_space_sel_n, program_space_sel_n, io_space_sel_n, space_sel_oe;
  logic memory_strobe_n, memory_strobe_oe, branch_condition_in_n, bus_hold, output_float_n;
  logic [31:0] rnd = 32'h0193;
  int bad_count = 0, n_compared = 0;
  // Reference state of the device, kept apart from the design.
  // The core starts fetching on the first edge after system reset.
  int flag = 1, mapbit = 0, cond = 0, run = 1;

  always #50 clk_sys = ~clk_sys;

  core_control_pins uut (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .reset_in_n(reset_in_n), .rom_map_select(rom_map_select),
    .program_counter(program_counter), .core_running(core_running), .rom_mapped(rom_mapped),
    .rom_select(rom_select), .branch_condition_in_n(branch_condition_in_n),
    .decode_phase(decode_phase), .read_phase(read_phase), .cond_test(cond_test),
    .cond_is_exec(cond_is_exec), .cond_valid(cond_valid), .cond_execute(cond_execute),
    .set_status_bit_instr(set_status_bit_instr),
    .clear_status_bit_instr(clear_status_bit_instr), .external_flag_out(external_flag_out),
    .external_flag_oe(external_flag_oe), .output_float_n(output_float_n), .bus_hold(bus_hold),
    .access_valid(access_valid), .access_space(access_space),
    .data_space_sel_n(data_space_sel_n), .program_space_sel_n(program_space_sel_n),
    .io_space_sel_n(io_space_sel_n), .space_sel_oe(space_sel_oe),
    .memory_strobe_n(memory_strobe_n), .memory_strobe_oe(memory_strobe_oe));

  far_side_model far (.cond_pin_cmd(cond_pin_cmd), .hold_cmd(hold_cmd), .float_cmd(float_cmd),
    .branch_condition_in_n(branch_condition_in_n), .bus_hold(bus_hold),
    .output_float_n(output_float_n));

  // ==========================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [15:0] state_word();
    return {12'h000, 1'(cond), 1'(run), 1'(mapbit), 1'(flag)};
  endfunction : state_word

  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask : cmp

  task automatic close_out();
    if (bad_count == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys) begin reg_addr <= a; reg_wdata <= d; reg_write <= 1'b1; end
    @(posedge clk_sys) reg_write <= 1'b0;
    @(negedge clk_sys);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk_sys) begin reg_addr <= a; reg_read <= 1'b1; end
    @(posedge clk_sys) reg_read <= 1'b0;
    @(negedge clk_sys) cmp(reg_rdata, e);
  endtask : rd

  // ==========================================================
  // Scenarios
  task automatic pin_reset(input logic m);
    @(posedge clk_sys) begin reset_in_n <= 1'b0; rom_map_select <= m; end
    @(posedge clk_sys);
    @(negedge clk_sys) begin flag = 1; mapbit = m; run = 0; end
    cmp(program_counter, core_control_pins_pkg::RESET_VECTOR);
    cmp({14'h0000, core_running, external_flag_out}, 16'h0001);
    cmp({15'h0000, rom_mapped}, {15'h0000, !m});
    // The pin flips at release so a design that keeps sampling it is caught.
    @(posedge clk_sys) begin reset_in_n <= 1'b1; rom_map_select <= !m; end
    @(posedge clk_sys);
    @(negedge clk_sys) run = 1;
    cmp(program_counter, core_control_pins_pkg::RESET_VECTOR);
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys) cmp(program_counter, core_control_pins_pkg::RESET_VECTOR + 16'h0003);
    cmp({13'h0000, core_running, rom_select, rom_mapped}, {13'h0001, !m, !m});
  endtask : pin_reset

  task automatic flag_op(input logic s, input logic c);
    @(posedge clk_sys) begin set_status_bit_instr <= s; clear_status_bit_instr <= c; end
    @(posedge clk_sys) begin set_status_bit_instr <= 1'b0; clear_status_bit_instr <= 1'b0; end
    @(negedge clk_sys) flag = s ? 1 : (c ? 0 : flag);
    cmp({15'h0000, external_flag_out}, {15'h0000, 1'(flag)});
  endtask : flag_op

  task automatic branch(input logic x, input logic a, input logic b);
    @(posedge clk_sys) begin cond_pin_cmd <= a; decode_phase <= 1'b1; end
    @(posedge clk_sys) begin decode_phase <= 1'b0; cond_pin_cmd <= b; read_phase <= 1'b1; end
    @(posedge clk_sys) begin read_phase <= 1'b0; cond_test <= 1'b1; cond_is_exec <= x; end
    @(posedge clk_sys) begin cond_test <= 1'b0; cond_pin_cmd <= !b; end
    @(negedge clk_sys) cond = x ? !a : !b;
    cmp({14'h0000, cond_valid, cond_execute}, {15'h0001, 1'(cond)});
  endtask : branch

  task automatic pins(input logic [31:0] r);
    logic f, h, v;
    logic [1:0] s;
    f = r[0] | r[1];
    h = r[2] & r[3];
    v = r[4] & !h;
    s = r[6:5];
    @(posedge clk_sys) begin float_cmd <= f; hold_cmd <= h; end
    @(posedge clk_sys) begin access_valid <= r[4]; access_space <= s; end
    @(posedge clk_sys);
    @(negedge clk_sys);
    cmp({external_flag_oe, space_sel_oe, memory_strobe_oe}, {f, f & !h, f & !h});
    cmp({data_space_sel_n, program_space_sel_n, io_space_sel_n},
        {!(v && s == 2'h0), !(v && s == 2'h1), !(v && s == 2'h2)});
    cmp({15'h0000, memory_strobe_n}, {15'h0000, !(v && s < 2'h2)});
  endtask : pins

  initial begin
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(negedge clk_sys) cmp({14'h0000, external_flag_out, core_running}, 16'h0002);
    rd(core_control_pins_pkg::STATE_OFS, state_word());
    pin_reset(1'b1);
    rd(core_control_pins_pkg::STATE_OFS, state_word());
    wr(core_control_pins_pkg::MODE_STATUS_OFS, 16'h0000);
    mapbit = 0;
    cmp({15'h0000, rom_mapped}, 16'h0001);
    pin_reset(1'b0);
    for (int i = 0; i < 16; i++) begin
      rnd = lfsr(rnd);
      flag_op(rnd[0], rnd[1]);
    end
    flag_op(1'b1, 1'b0);
    wr(core_control_pins_pkg::STATUS1_OFS, rnd[15:0]);
    flag = 0;
    rd(core_control_pins_pkg::STATUS1_OFS, 16'h0000);
    for (int i = 0; i < 16; i++) begin
      rnd = lfsr(rnd);
      branch(1'(i), rnd[1], rnd[2]);
    end
    rd(core_control_pins_pkg::STATE_OFS, state_word());
    rd(4'hc, 16'h0000);
    for (int i = 0; i < 48; i++) begin
      rnd = lfsr(rnd);
      pins(rnd);
    end
    close_out();
  end

  // The whole run needs well under two thousand cycles; this only catches a hang.
  initial begin
    #1000000;
    bad_count++;
    close_out();
  end
endmodule : test_core_control_pins
